// ### rtl/adcc_pkg.sv
// Constants and types shared by the converter control logic.
package adcc_pkg;

    // ----------------------------------------------------------------
    // Data widths and result layout
    // ----------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int CHAN_W = 3;
    localparam int BYTE_W = 8;
    localparam int HIGH_LSB = 2;
    localparam int LOW_MSB = 1;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // Saturation and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] SAT_HIGH = 8'hff;
    localparam logic [7:0] SAT_LOW = 8'h03;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_FULL = 10'h3ff;

    // ----------------------------------------------------------------
    // Timing: one conversion lasts CONV_TIME_NS at the 10 MHz system clock
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_CONVERT = 2'b01,
        ADCC_PUSH = 2'b10
    } adcc_state_t;

endpackage : adcc_pkg

// ### rtl/adcc_top.sv
// Converter sequencing, result FIFO and result registers.
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
module adcc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Discard all entries
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    // Full and empty follow the occupancy count directly.
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge clk_sys)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and count; a flush empties the queue.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : adcc_fifo

// ----------------------------------------------------------------
// Converter control top
// ----------------------------------------------------------------
// Function
// - Converter-on bit enables and starts conversion
// - Convert selected channel back to back while enabled, pausing while the result queue is full
// - Three-bit field selects sampled channel
// - Conversion end sets done flag, loads result
// - Reading high result clears done flag
// - Over upper reference saturates to FFh/03h
// - Below lower reference gives all zeros
// - Amplifier powered by converter-on bit together with amplifier-select bit
module adcc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control bits of the control/status register
    input wire logic converter_on_bit,
    input wire logic amplifier_select_bit,
    input wire logic [2:0] chan_sel,
    // Status and result registers
    output logic conv_done,
    output logic [7:0] result_high_reg,
    output logic [7:0] result_low_reg,
    // Read strobes from software
    input wire logic rd_high,
    input wire logic rd_low,
    // Analog front end
    output logic afe_power,
    output logic afe_amp_en,
    output logic [2:0] afe_chan,
    output logic afe_sample,
    input wire logic [9:0] afe_code,
    input wire logic afe_over,
    input wire logic afe_under,
    // Converter stalled by a full result queue
    output logic conv_stall
);
    adcc_pkg::adcc_state_t state;
    logic [adcc_pkg::CNT_W-1:0] cnt;
    logic [adcc_pkg::RES_W-1:0] sample;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [adcc_pkg::RES_W-1:0] fifo_out_data;
    logic load;

    // Clamp a raw code at the reference limits.
    function automatic logic [9:0] clamp_code(input logic [9:0] code, input logic over, input logic under);
        if (over)
        begin
            clamp_code = adcc_pkg::CODE_FULL;
        end
        else if (under)
        begin
            clamp_code = adcc_pkg::CODE_ZERO;
        end
        else
        begin
            clamp_code = code;
        end
    endfunction : clamp_code

    // Front-end power follows the converter-on bit alone; the amplifier also needs the amplifier-select bit.
    assign afe_power = converter_on_bit;
    assign afe_amp_en = converter_on_bit && amplifier_select_bit;
    assign afe_chan = chan_sel;
    assign afe_sample = (state == adcc_pkg::ADCC_CONVERT) && (cnt == '0);
    assign conv_stall = (state == adcc_pkg::ADCC_PUSH) && !fifo_in_ready;

    // Sequencer: start on enable, convert back to back, wait on a full queue.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= adcc_pkg::ADCC_IDLE;
            cnt <= '0;
            sample <= '0;
        end
        else if (!converter_on_bit)
        begin
            state <= adcc_pkg::ADCC_IDLE;
            cnt <= '0;
        end
        else
        begin
            case (state)
                adcc_pkg::ADCC_IDLE:
                begin
                    state <= adcc_pkg::ADCC_CONVERT;
                    cnt <= '0;
                end
                adcc_pkg::ADCC_CONVERT:
                begin
                    if (cnt == adcc_pkg::CONV_LAST)
                    begin
                        sample <= clamp_code(afe_code, afe_over, afe_under);
                        state <= adcc_pkg::ADCC_PUSH;
                    end
                    else
                    begin
                        cnt <= cnt + 1'b1;
                    end
                end
                adcc_pkg::ADCC_PUSH:
                begin
                    if (fifo_in_ready)
                    begin
                        state <= adcc_pkg::ADCC_CONVERT;
                        cnt <= '0;
                    end
                end
                default:
                begin
                    state <= adcc_pkg::ADCC_IDLE;
                end
            endcase
        end
    end

    // Results wait here until software has taken the previous one.
    adcc_fifo #(
        .WIDTH(adcc_pkg::RES_W),
        .DEPTH(adcc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .in_valid(state == adcc_pkg::ADCC_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(sample),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .flush(!converter_on_bit)
    );

    // A new result is loaded when the registers are free or being released.
    assign fifo_out_ready = !conv_done || rd_high;
    assign load = fifo_out_valid && fifo_out_ready;

    // Result registers, split into high and low parts.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            result_high_reg <= adcc_pkg::RESULT_RESET;
            result_low_reg <= adcc_pkg::RESULT_RESET;
        end
        else if (load)
        begin
            result_high_reg <= fifo_out_data[adcc_pkg::RES_W-1:adcc_pkg::HIGH_LSB];
            result_low_reg <= {6'h00, fifo_out_data[adcc_pkg::LOW_MSB:0]};
        end
    end

    // Done flag: a new result wins over a clearing read in the same cycle.
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            conv_done <= 1'b0;
        end
        else if (load)
        begin
            conv_done <= 1'b1;
        end
        else if (rd_high)
        begin
            conv_done <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Checks of the sequencing and result behaviour.
    enable_starts_a: assert property ($rose(converter_on_bit) && state == adcc_pkg::ADCC_IDLE
        |=> state == adcc_pkg::ADCC_CONVERT ##0 afe_sample)
        else $error("Enable did not start a conversion.");
    back_to_back_a: assert property (state == adcc_pkg::ADCC_PUSH && fifo_in_ready && converter_on_bit
        |=> afe_sample)
        else $error("Next conversion did not start at once.");
    // A conversion lasts 40 cycles from its start pulse; dropping the enable abandons the check.
    conv_length_a: assert property (disable iff (!nrst || !converter_on_bit) afe_sample
        |-> ##40 state == adcc_pkg::ADCC_PUSH)
        else $error("Conversion length wrong.");
    chan_follow_a: assert property (afe_chan == chan_sel)
        else $error("Channel select not passed on.");
    done_set_a: assert property (load |=> conv_done
        && {result_high_reg, result_low_reg[1:0]} == $past(fifo_out_data))
        else $error("Result load did not set done.");
    high_clear_a: assert property (rd_high && conv_done && !fifo_out_valid |=> !conv_done)
        else $error("High read did not clear done.");
    low_keeps_a: assert property (rd_low && !rd_high && conv_done |=> conv_done)
        else $error("Low read disturbed done.");
    sat_high_a: assert property (state == adcc_pkg::ADCC_CONVERT && cnt == adcc_pkg::CONV_LAST
        && converter_on_bit && afe_over |=> sample == adcc_pkg::CODE_FULL)
        else $error("Over range not saturated.");
    sat_low_a: assert property (state == adcc_pkg::ADCC_CONVERT && cnt == adcc_pkg::CONV_LAST
        && converter_on_bit && afe_under && !afe_over |=> sample == adcc_pkg::CODE_ZERO)
        else $error("Under range not zero.");
    amp_power_a: assert property (afe_amp_en |-> afe_power && amplifier_select_bit)
        else $error("Amplifier on without converter.");
    low_upper_a: assert property (result_low_reg[7:2] == 6'h00)
        else $error("Low result upper bits not zero.");

    // Main scenarios.
    full_read_c: cover property (conv_done ##1 rd_low ##[1:4] rd_high);
    stall_c: cover property (conv_stall [*3]);
    saturate_c: cover property (load && fifo_out_data == adcc_pkg::CODE_FULL);
    set_clear_c: cover property (load && rd_high && conv_done);
endmodule : adcc_top

// ### verification/adcc_afe_model.sv
// Behavioural analog front end that answers the converter control.
`timescale 1ns/10ps
module adcc_afe_model (
    // Clock
    input wire logic clk_sys,
    // Front end controls from the converter
    input wire logic afe_power,
    input wire logic [2:0] afe_chan,
    // Test controls for the input level
    input wire logic over_req,
    input wire logic under_req,
    // Answers to the converter
    output logic [9:0] afe_code,
    output logic afe_over,
    output logic afe_under
);
    logic [9:0] noise = 10'h155;

    // An unpowered front end shows a pattern that moves every cycle, never a held value.
    always_ff @(posedge clk_sys)
    begin
        noise <= noise + 10'h12d;
    end

    // Each channel carries its own fixed level.
    assign afe_code = afe_power ? 10'h02a + 10'h061 * {7'h00, afe_chan} : noise;
    assign afe_over = afe_power & over_req;
    assign afe_under = afe_power & under_req;
endmodule : adcc_afe_model

// ### verification/tb_adcc_top.sv
// Self-checking testbench for the converter control top.
`timescale 1ns/10ps
module tb_adcc_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic converter_on_bit = 1'b0;
    logic amplifier_select_bit = 1'b0;
    logic [2:0] chan_sel = 3'h0;
    logic rd_high = 1'b0;
    logic rd_low = 1'b0;
    logic over_req = 1'b0;
    logic under_req = 1'b0;
    logic conv_done, afe_power, afe_amp_en, afe_sample, conv_stall, afe_over, afe_under;
    logic [7:0] result_high_reg, result_low_reg;
    logic [2:0] afe_chan;
    logic [9:0] afe_code;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // The system clock runs at 10 MHz.
    always #50 clk_sys = ~clk_sys;

    adcc_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .converter_on_bit(converter_on_bit),
        .amplifier_select_bit(amplifier_select_bit), .chan_sel(chan_sel), .conv_done(conv_done),
        .result_high_reg(result_high_reg), .result_low_reg(result_low_reg), .rd_high(rd_high),
        .rd_low(rd_low), .afe_power(afe_power), .afe_amp_en(afe_amp_en), .afe_chan(afe_chan),
        .afe_sample(afe_sample), .afe_code(afe_code), .afe_over(afe_over), .afe_under(afe_under),
        .conv_stall(conv_stall));

    adcc_afe_model u_afe (.clk_sys(clk_sys), .afe_power(afe_power), .afe_chan(afe_chan),
        .over_req(over_req), .under_req(under_req), .afe_code(afe_code), .afe_over(afe_over),
        .afe_under(afe_under));

    // Level that the front end model gives for a channel.
    function automatic logic [9:0] code_of(input int ch);
        return 10'h02a + 10'h061 * 10'(ch);
    endfunction : code_of

    // Prints the verdict and ends the run.
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // Compares one value and counts the outcome.
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Polls the done flag under a bounded count.
    task automatic wait_done;
        int i;
        i = 0;
        @(negedge clk_sys);
        while (conv_done !== 1'b1 && i < 200)
        begin
            @(negedge clk_sys);
            i++;
        end
        check("conv_done", 10'h001, {9'h000, conv_done});
    endtask : wait_done

    // Software read: poll, optional low read, then high read.
    task automatic read_result(input logic [9:0] exp, input logic use_low);
        wait_done();
        if (use_low)
        begin
            @(posedge clk_sys);
            rd_low <= 1'b1;
            @(posedge clk_sys);
            rd_low <= 1'b0;
            @(negedge clk_sys);
            check("done_after_low", 10'h001, {9'h000, conv_done});
        end
        check("result", exp, {result_high_reg, result_low_reg[1:0]});
        check("low_top", 10'h000, {4'h0, result_low_reg[7:2]});
        @(posedge clk_sys);
        rd_high <= 1'b1;
        @(posedge clk_sys);
        rd_high <= 1'b0;
    endtask : read_result

    // Turns the converter off, then a high read must leave the flag clear.
    task automatic stop_conv;
        @(posedge clk_sys);
        converter_on_bit <= 1'b0;
        @(posedge clk_sys);
        rd_high <= 1'b1;
        @(posedge clk_sys);
        rd_high <= 1'b0;
        @(negedge clk_sys);
        check("done_cleared", 10'h000, {9'h000, conv_done});
        check("afe_power_off", 10'h000, {9'h000, afe_power});
        check("afe_amp_off", 10'h000, {9'h000, afe_amp_en});
    endtask : stop_conv

    // Cuts a hang short.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // Main sequence.
    initial
    begin
        int i;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        check("reset_done", 10'h000, {9'h000, conv_done});
        check("reset_result", 10'h000, {result_high_reg, result_low_reg[1:0]});
        for (int ch = 0; ch < 8; ch++)
        begin
            @(posedge clk_sys);
            chan_sel <= 3'(ch);
            amplifier_select_bit <= ch[0];
            converter_on_bit <= 1'b1;
            @(posedge clk_sys);
            @(negedge clk_sys);
            check("afe_sample", 10'h001, {9'h000, afe_sample});
            check("afe_chan", 10'(ch), {7'h00, afe_chan});
            check("afe_amp_en", {9'h000, ch[0]}, {9'h000, afe_amp_en});
            check("afe_power", 10'h001, {9'h000, afe_power});
            read_result(code_of(ch), ch[0]);
            stop_conv();
        end
        for (int k = 0; k < 3; k++)
        begin
            @(posedge clk_sys);
            over_req <= (k != 1);
            under_req <= (k != 0);
            converter_on_bit <= 1'b1;
            read_result((k == 1) ? 10'h000 : 10'h3ff, 1'b1);
            stop_conv();
        end
        @(posedge clk_sys);
        over_req <= 1'b0;
        under_req <= 1'b0;
        chan_sel <= 3'h5;
        converter_on_bit <= 1'b1;
        i = 0;
        @(negedge clk_sys);
        while (conv_stall !== 1'b1 && i < 600)
        begin
            @(negedge clk_sys);
            i++;
        end
        check("conv_stall", 10'h001, {9'h000, conv_stall});
        read_result(code_of(5), 1'b0);
        @(negedge clk_sys);
        check("stall_freed", 10'h000, {9'h000, conv_stall});
        for (int n = 0; n < 9; n++)
            read_result(code_of(5), 1'b0);
        stop_conv();
        complete_run();
    end
endmodule : tb_adcc_top
